// >>> logic/dlsup_pkg.sv
/*
 dlsup_pkg: constants, register map, modes, states and carriers of the
 dead-line detector and vt circuit supervisor.
 Assumes a 250 MHz core clock and magnitudes in percent of nominal with
 four fractional bits.
*/
package dlsup_pkg;

	// clock and timing strobe
	localparam int CLK_MHZ         = 250;
	localparam int TICK_US         = 1000;
	localparam int TICK_CYCLES_DEF = TICK_US * CLK_MHZ;

	// qualifier times in ms; one extra tick covers the partial first tick
	localparam int ARM_MS   = 200;
	localparam int QUAL_MS  = 4;
	localparam int CLEAR_MS = 200;
	localparam int LATCH_MS = 100;
	localparam int ARM_TICKS   = (ARM_MS * 1000 + TICK_US - 1) / TICK_US + 1;
	localparam int QUAL_TICKS  = (QUAL_MS * 1000 + TICK_US - 1) / TICK_US + 1;
	localparam int CLEAR_TICKS = (CLEAR_MS * 1000 + TICK_US - 1) / TICK_US + 1;
	localparam int LATCH_TICKS = (LATCH_MS * 1000 + TICK_US - 1) / TICK_US + 1;

	localparam int TMR_W = 8;
	localparam logic [TMR_W-1:0] ARM_LIM   = TMR_W'(ARM_TICKS);
	localparam logic [TMR_W-1:0] QUAL_LIM  = TMR_W'(QUAL_TICKS);
	localparam logic [TMR_W-1:0] CLEAR_LIM = TMR_W'(CLEAR_TICKS);
	localparam logic [TMR_W-1:0] LATCH_LIM = TMR_W'(LATCH_TICKS);

	// magnitudes and settings
	localparam int MAG_W  = 16;
	localparam int FRAC_W = 4;
	localparam int PCT_W  = 7;
	localparam int PROD_W = MAG_W + 5;
	localparam logic [4:0] HYS_NUM = 5'h13;
	localparam logic [4:0] HYS_DEN = 5'h14;

	localparam logic [PCT_W-1:0] VTHR_MIN    = 7'h0A;
	localparam logic [PCT_W-1:0] VTHR_MAX    = 7'h64;
	localparam logic [PCT_W-1:0] VTHR_RST    = 7'h3C;
	localparam logic [PCT_W-1:0] ITHR_MIN    = 7'h02;
	localparam logic [PCT_W-1:0] ITHR_MAX    = 7'h64;
	localparam logic [PCT_W-1:0] ITHR_RST    = 7'h0A;
	localparam logic [PCT_W-1:0] SV_VTHR_RST = 7'h1E;
	localparam logic [PCT_W-1:0] SV_ITHR_RST = 7'h0A;

	// register map
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] REG_CTRL    = 12'h000;
	localparam logic [ADDR_W-1:0] REG_DLD_THR = 12'h004;
	localparam logic [ADDR_W-1:0] REG_SUP_THR = 12'h008;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 12'h00C;

	localparam int CTRL_ON_BIT  = 0;
	localparam int CTRL_MODE_LO = 1;
	localparam int THR_V_LO     = 0;
	localparam int THR_I_LO     = 8;
	localparam int ST_DEAD_BIT  = 0;
	localparam int ST_LIVE_BIT  = 1;
	localparam int ST_VOVR_LO   = 2;
	localparam int ST_IOVR_LO   = 5;
	localparam int ST_ARMED_BIT = 8;
	localparam int ST_FAULT_BIT = 9;
	localparam int ST_LATCH_BIT = 10;

	// comparator channel indices
	localparam int NCMP   = 10;
	localparam int CH_V1  = 0;
	localparam int CH_I1  = 3;
	localparam int CH_RV  = 6;
	localparam int CH_RI  = 7;
	localparam int CH_NV  = 8;
	localparam int CH_NI  = 9;

	typedef enum logic [1:0] {
		MODE_ZERO    = 2'h0,
		MODE_NEG     = 2'h1,
		MODE_SPECIAL = 2'h2
	} dlsup_mode_t;

	typedef enum logic [3:0] {
		SUP_IDLE    = 4'h1,
		SUP_ARMED   = 4'h2,
		SUP_FAULT   = 4'h4,
		SUP_LATCHED = 4'h8
	} dlsup_state_t;

	typedef struct packed {
		logic [MAG_W-1:0] l3;
		logic [MAG_W-1:0] l2;
		logic [MAG_W-1:0] l1;
	} dlsup_phase_mag_t;

	typedef struct packed {
		logic [MAG_W-1:0] residual_voltage;
		logic [MAG_W-1:0] residual_current;
		logic [MAG_W-1:0] neg_seq_voltage;
		logic [MAG_W-1:0] neg_seq_current;
	} dlsup_seq_mag_t;

endpackage : dlsup_pkg

// >>> logic/dlsup_cmp.sv
/*
 dlsup_cmp: one magnitude comparator with a 0.95 release ratio and a
 registered flag.
 Assumes magnitude and pickup on the core clock, same scaling.
*/
`timescale 1ns/1ns
module dlsup_cmp (
	// clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        rst_b,
	// operands
	input  wire logic                        clear,
	input  wire logic [dlsup_pkg::MAG_W-1:0] mag,
	input  wire logic [dlsup_pkg::MAG_W-1:0] pick,
	// result
	output logic                             over
);

	logic [dlsup_pkg::PROD_W-1:0] mag_scaled;
	logic [dlsup_pkg::PROD_W-1:0] pick_scaled;

	assign mag_scaled  = dlsup_pkg::PROD_W'(mag) * dlsup_pkg::PROD_W'(dlsup_pkg::HYS_DEN);
	assign pick_scaled = dlsup_pkg::PROD_W'(pick) * dlsup_pkg::PROD_W'(dlsup_pkg::HYS_NUM);

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			over <= 1'b0;
		else if (clear)
			over <= 1'b0;
		else if (mag > pick)
			over <= 1'b1;
		else if (mag_scaled < pick_scaled)
			over <= 1'b0; // see R23
	end

endmodule : dlsup_cmp

// >>> logic/dlsup_top.sv
/*
 dlsup_top: dead-line / live-line detector with per-phase flags and a vt
 circuit supervisor, settings and status over APB.
 Assumes magnitudes come from front-end logic on core_clk, the inhibit
 from user logic on core_clk, and an APB master on the same clock.
*/
`timescale 1ns/1ns
// Function
// R1: dead flag only when all voltages and all currents are below threshold.
// R2: live flag when all three voltages are above threshold.
// R3: voltage threshold 10 to 100 percent, step one, reset 60.
// R4: current threshold 2 to 100 percent, step one, reset 10.
// R5: on/off setting, reset off; when off all detector outputs low.
// R6: user inhibit input disables the detector while high.
// R7: one voltage-over flag per phase.
// R8: one current-over flag per phase.
// R9: dead and live flags on outputs and in a readable status.
// R10: detector makes no event records, only flags and status.
// R11: zero-sequence mode: residual voltage high and residual current low.
// R12: negative mode: negative voltage high and negative current low.
// R13: special mode: residual voltage high, residual and negative current low.
// R14: supervisor arms after live flag held 200 ms.
// R15: dead line returns supervisor to unarmed, except when latched.
// R16: armed: fault output after condition held 4 ms.
// R17: supervisor works only while detector is enabled and not inhibited.
// R18: condition gone on live line: fault output clears after 200 ms.
// R19: dead line after 100 ms of fault: output latched through dead time.
// R20: dead line before 100 ms of fault: output cleared.
// R21: front end supplies per-phase fundamental magnitudes.
// R22: front end supplies residual and negative-sequence magnitudes.
// R23: comparators release at 0.95 of pickup.
// R24: settings hold supervisor mode and its own thresholds.
// R25: delays counted in ticks of a fixed strobe; counters restart on drop.
module dlsup_top #(
	parameter int TICK_CYCLES = dlsup_pkg::TICK_CYCLES_DEF
) (
	// clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         rst_b,
	// apb slave
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [dlsup_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	// magnitudes from the front end
	input  wire dlsup_pkg::dlsup_phase_mag_t  phase_voltage,
	input  wire dlsup_pkg::dlsup_phase_mag_t  phase_current,
	input  wire dlsup_pkg::dlsup_seq_mag_t    seq_mag,
	// user logic
	input  wire logic                         detector_inhibit,
	// flags
	output logic                              phase1_voltage_over,
	output logic                              phase2_voltage_over,
	output logic                              phase3_voltage_over,
	output logic                              phase1_current_over,
	output logic                              phase2_current_over,
	output logic                              phase3_current_over,
	output logic                              line_dead_flag,
	output logic                              line_live_flag,
	output logic                              vt_circuit_fault
);

	localparam int TICK_W = $clog2(TICK_CYCLES);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

	// settings
	logic                           detector_on;
	dlsup_pkg::dlsup_mode_t         sup_mode;
	logic [dlsup_pkg::PCT_W-1:0]    dld_vthr;
	logic [dlsup_pkg::PCT_W-1:0]    dld_ithr;
	logic [dlsup_pkg::PCT_W-1:0]    sup_vthr;
	logic [dlsup_pkg::PCT_W-1:0]    sup_ithr;

	// bus
	logic                           apb_access;
	logic                           apb_done;
	logic [31:0]                    next_prdata;
	logic                           next_slverr;

	// comparators
	logic [dlsup_pkg::MAG_W-1:0]    cmp_mag  [dlsup_pkg::NCMP];
	logic [dlsup_pkg::MAG_W-1:0]    cmp_pick [dlsup_pkg::NCMP];
	logic [dlsup_pkg::NCMP-1:0]     cmp_over;
	logic [dlsup_pkg::MAG_W-1:0]    dld_vpick;
	logic [dlsup_pkg::MAG_W-1:0]    dld_ipick;
	logic [dlsup_pkg::MAG_W-1:0]    sup_vpick;
	logic [dlsup_pkg::MAG_W-1:0]    sup_ipick;
	logic                           operable;
	logic [2:0]                     v_over;
	logic [2:0]                     i_over;

	// supervisor
	logic [TICK_W-1:0]              tick_cnt;
	logic                           tick;
	logic [dlsup_pkg::TMR_W-1:0]    arm_cnt;
	logic [dlsup_pkg::TMR_W-1:0]    qual_cnt;
	logic [dlsup_pkg::TMR_W-1:0]    hold_cnt;
	logic [dlsup_pkg::TMR_W-1:0]    clr_cnt;
	logic                           fault_cond;
	dlsup_pkg::dlsup_state_t        sup_state;
	dlsup_pkg::dlsup_state_t        next_sup_state;

	function automatic logic [dlsup_pkg::PCT_W-1:0] clamp_pct(
		input logic [dlsup_pkg::PCT_W-1:0] val,
		input logic [dlsup_pkg::PCT_W-1:0] lo,
		input logic [dlsup_pkg::PCT_W-1:0] hi
	);
		if (val < lo)
			return lo;
		else if (val > hi)
			return hi;
		else
			return val;
	endfunction : clamp_pct

	// apb: one wait state, writes land with pready high
	assign apb_access = psel & penable & ~pready;
	assign apb_done   = psel & penable & pready;

	always_comb
	begin
		next_prdata = 32'h0000_0000;
		next_slverr = 1'b0;
		case (paddr)
			dlsup_pkg::REG_CTRL:
			begin
				next_prdata[dlsup_pkg::CTRL_ON_BIT] = detector_on;
				next_prdata[dlsup_pkg::CTRL_MODE_LO +: 2] = sup_mode;
			end
			dlsup_pkg::REG_DLD_THR:
			begin
				next_prdata[dlsup_pkg::THR_V_LO +: dlsup_pkg::PCT_W] = dld_vthr;
				next_prdata[dlsup_pkg::THR_I_LO +: dlsup_pkg::PCT_W] = dld_ithr;
			end
			dlsup_pkg::REG_SUP_THR:
			begin
				next_prdata[dlsup_pkg::THR_V_LO +: dlsup_pkg::PCT_W] = sup_vthr;
				next_prdata[dlsup_pkg::THR_I_LO +: dlsup_pkg::PCT_W] = sup_ithr;
			end
			dlsup_pkg::REG_STATUS:
			begin
				next_prdata[dlsup_pkg::ST_DEAD_BIT] = line_dead_flag; // see R9
				next_prdata[dlsup_pkg::ST_LIVE_BIT] = line_live_flag; // see R9
				next_prdata[dlsup_pkg::ST_VOVR_LO +: 3] = v_over;
				next_prdata[dlsup_pkg::ST_IOVR_LO +: 3] = i_over;
				next_prdata[dlsup_pkg::ST_ARMED_BIT] = (sup_state == dlsup_pkg::SUP_ARMED);
				next_prdata[dlsup_pkg::ST_FAULT_BIT] = vt_circuit_fault;
				next_prdata[dlsup_pkg::ST_LATCH_BIT] = (sup_state == dlsup_pkg::SUP_LATCHED);
			end
			default:
				next_slverr = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= apb_access;
			pslverr <= apb_access & next_slverr;
			if (apb_access)
				prdata <= pwrite ? 32'h0000_0000 : next_prdata;
		end
	end

	// settings registers; out-of-range thresholds are pulled into range, a mode write of 3 is ignored
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			detector_on <= 1'b0; // see R5
			sup_mode    <= dlsup_pkg::MODE_ZERO;
			dld_vthr    <= dlsup_pkg::VTHR_RST; // see R3
			dld_ithr    <= dlsup_pkg::ITHR_RST; // see R4
			sup_vthr    <= dlsup_pkg::SV_VTHR_RST;
			sup_ithr    <= dlsup_pkg::SV_ITHR_RST;
		end
		else if (apb_done && pwrite)
		begin
			case (paddr)
				dlsup_pkg::REG_CTRL:
				begin
					detector_on <= pwdata[dlsup_pkg::CTRL_ON_BIT];
					if (pwdata[dlsup_pkg::CTRL_MODE_LO +: 2] != 2'h3)
						sup_mode <= dlsup_pkg::dlsup_mode_t'(pwdata[dlsup_pkg::CTRL_MODE_LO +: 2]); // see R24
				end
				dlsup_pkg::REG_DLD_THR:
				begin
					dld_vthr <= clamp_pct(pwdata[dlsup_pkg::THR_V_LO +: dlsup_pkg::PCT_W],
						dlsup_pkg::VTHR_MIN, dlsup_pkg::VTHR_MAX); // see R3
					dld_ithr <= clamp_pct(pwdata[dlsup_pkg::THR_I_LO +: dlsup_pkg::PCT_W],
						dlsup_pkg::ITHR_MIN, dlsup_pkg::ITHR_MAX); // see R4
				end
				dlsup_pkg::REG_SUP_THR:
				begin
					sup_vthr <= clamp_pct(pwdata[dlsup_pkg::THR_V_LO +: dlsup_pkg::PCT_W],
						dlsup_pkg::VTHR_MIN, dlsup_pkg::VTHR_MAX); // see R24
					sup_ithr <= clamp_pct(pwdata[dlsup_pkg::THR_I_LO +: dlsup_pkg::PCT_W],
						dlsup_pkg::ITHR_MIN, dlsup_pkg::ITHR_MAX); // see R24
				end
				default:
				begin
				end
			endcase
		end
	end

	// comparator channels
	assign operable  = detector_on & ~detector_inhibit; // see R5, see R6, see R17
	assign dld_vpick = dlsup_pkg::MAG_W'({dld_vthr, {dlsup_pkg::FRAC_W{1'b0}}});
	assign dld_ipick = dlsup_pkg::MAG_W'({dld_ithr, {dlsup_pkg::FRAC_W{1'b0}}});
	assign sup_vpick = dlsup_pkg::MAG_W'({sup_vthr, {dlsup_pkg::FRAC_W{1'b0}}});
	assign sup_ipick = dlsup_pkg::MAG_W'({sup_ithr, {dlsup_pkg::FRAC_W{1'b0}}});

	assign cmp_mag[dlsup_pkg::CH_V1]     = phase_voltage.l1;
	assign cmp_mag[dlsup_pkg::CH_V1 + 1] = phase_voltage.l2;
	assign cmp_mag[dlsup_pkg::CH_V1 + 2] = phase_voltage.l3;
	assign cmp_mag[dlsup_pkg::CH_I1]     = phase_current.l1;
	assign cmp_mag[dlsup_pkg::CH_I1 + 1] = phase_current.l2;
	assign cmp_mag[dlsup_pkg::CH_I1 + 2] = phase_current.l3;
	assign cmp_mag[dlsup_pkg::CH_RV]     = seq_mag.residual_voltage;
	assign cmp_mag[dlsup_pkg::CH_RI]     = seq_mag.residual_current;
	assign cmp_mag[dlsup_pkg::CH_NV]     = seq_mag.neg_seq_voltage;
	assign cmp_mag[dlsup_pkg::CH_NI]     = seq_mag.neg_seq_current;

	generate
		for (genvar ch = 0; ch < dlsup_pkg::NCMP; ch++)
		begin : g_cmp
			if (ch < dlsup_pkg::CH_I1)
				assign cmp_pick[ch] = dld_vpick;
			else if (ch < dlsup_pkg::CH_RV)
				assign cmp_pick[ch] = dld_ipick;
			else if (ch == dlsup_pkg::CH_RV || ch == dlsup_pkg::CH_NV)
				assign cmp_pick[ch] = sup_vpick;
			else
				assign cmp_pick[ch] = sup_ipick;

			dlsup_cmp u_cmp (
				.core_clk (core_clk),
				.rst_b    (rst_b),
				.clear    (~operable),
				.mag      (cmp_mag[ch]),
				.pick     (cmp_pick[ch]),
				.over     (cmp_over[ch])
			);
		end
	endgenerate

	assign v_over = cmp_over[dlsup_pkg::CH_V1 +: 3];
	assign i_over = cmp_over[dlsup_pkg::CH_I1 +: 3];

	assign phase1_voltage_over = v_over[0]; // see R7
	assign phase2_voltage_over = v_over[1]; // see R7
	assign phase3_voltage_over = v_over[2]; // see R7
	assign phase1_current_over = i_over[0]; // see R8
	assign phase2_current_over = i_over[1]; // see R8
	assign phase3_current_over = i_over[2]; // see R8

	// line state; flags and status only, nothing is recorded (see R10)
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			line_dead_flag <= 1'b0;
			line_live_flag <= 1'b0;
		end
		else
		begin
			line_dead_flag <= operable & ~(|v_over) & ~(|i_over); // see R1
			line_live_flag <= operable & (&v_over); // see R2
		end
	end

	// fault condition of the selected mode
	always_comb
	begin
		case (sup_mode)
			dlsup_pkg::MODE_ZERO:
				fault_cond = cmp_over[dlsup_pkg::CH_RV] & ~cmp_over[dlsup_pkg::CH_RI]; // see R11
			dlsup_pkg::MODE_NEG:
				fault_cond = cmp_over[dlsup_pkg::CH_NV] & ~cmp_over[dlsup_pkg::CH_NI]; // see R12
			dlsup_pkg::MODE_SPECIAL:
				fault_cond = cmp_over[dlsup_pkg::CH_RV] & ~cmp_over[dlsup_pkg::CH_RI]
					& ~cmp_over[dlsup_pkg::CH_NI]; // see R13
			default:
				fault_cond = 1'b0;
		endcase
	end

	// 1 ms timing strobe
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end
		else
		begin
			tick     <= (tick_cnt == TICK_LAST); // see R25
			tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
		end
	end

	// qualifier timers, each restarts when its condition drops
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			arm_cnt <= '0;
		else if (!operable || !line_live_flag)
			arm_cnt <= '0; // see R25
		else if (tick && arm_cnt != dlsup_pkg::ARM_LIM)
			arm_cnt <= arm_cnt + 1'b1; // see R14
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			qual_cnt <= '0;
		else if (sup_state != dlsup_pkg::SUP_ARMED || !fault_cond)
			qual_cnt <= '0; // see R25
		else if (tick && qual_cnt != dlsup_pkg::QUAL_LIM)
			qual_cnt <= qual_cnt + 1'b1; // see R16
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			hold_cnt <= '0;
		else if (sup_state != dlsup_pkg::SUP_FAULT && sup_state != dlsup_pkg::SUP_LATCHED)
			hold_cnt <= '0;
		else if (tick && hold_cnt != dlsup_pkg::LATCH_LIM)
			hold_cnt <= hold_cnt + 1'b1; // see R19
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			clr_cnt <= '0;
		else if (sup_state != dlsup_pkg::SUP_FAULT || fault_cond || !line_live_flag)
			clr_cnt <= '0; // see R25
		else if (tick && clr_cnt != dlsup_pkg::CLEAR_LIM)
			clr_cnt <= clr_cnt + 1'b1; // see R18
	end

	// supervisor sequence
	always_comb
	begin
		next_sup_state = sup_state;
		case (sup_state)
			dlsup_pkg::SUP_IDLE:
				if (operable && !line_dead_flag && arm_cnt == dlsup_pkg::ARM_LIM)
					next_sup_state = dlsup_pkg::SUP_ARMED; // see R14
			dlsup_pkg::SUP_ARMED:
				if (!operable || line_dead_flag)
					next_sup_state = dlsup_pkg::SUP_IDLE; // see R15, see R17
				else if (qual_cnt == dlsup_pkg::QUAL_LIM)
					next_sup_state = dlsup_pkg::SUP_FAULT; // see R16
			dlsup_pkg::SUP_FAULT:
				if (!operable)
					next_sup_state = dlsup_pkg::SUP_IDLE; // see R17
				else if (line_dead_flag)
					next_sup_state = (hold_cnt == dlsup_pkg::LATCH_LIM)
						? dlsup_pkg::SUP_LATCHED // see R19
						: dlsup_pkg::SUP_IDLE; // see R20
				else if (clr_cnt == dlsup_pkg::CLEAR_LIM)
					next_sup_state = dlsup_pkg::SUP_ARMED; // see R18
			dlsup_pkg::SUP_LATCHED:
				if (!operable)
					next_sup_state = dlsup_pkg::SUP_IDLE; // see R17
				else if (line_live_flag)
					next_sup_state = dlsup_pkg::SUP_FAULT; // see R19
			default:
				next_sup_state = dlsup_pkg::SUP_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sup_state        <= dlsup_pkg::SUP_IDLE;
			vt_circuit_fault <= 1'b0;
		end
		else
		begin
			sup_state        <= next_sup_state;
			vt_circuit_fault <= (next_sup_state == dlsup_pkg::SUP_FAULT)
				|| (next_sup_state == dlsup_pkg::SUP_LATCHED); // see R16, see R19
		end
	end

endmodule : dlsup_top

// >>> tb/dlsup_fe_model.sv
/*
 dlsup_fe_model: front end that turns commanded percent levels into
 fundamental magnitudes, one sample per clock.
 Assumes levels driven on core_clk.
*/
`timescale 1ns/1ns
module dlsup_fe_model (
	// clock
	input  wire logic                   core_clk,
	// commanded levels in percent
	input  wire logic [2:0][7:0]        vp,
	input  wire logic [2:0][7:0]        ip,
	input  wire logic [3:0][7:0]        sp,
	// magnitudes
	output dlsup_pkg::dlsup_phase_mag_t phase_voltage,
	output dlsup_pkg::dlsup_phase_mag_t phase_current,
	output dlsup_pkg::dlsup_seq_mag_t   seq_mag
);
	function automatic logic [15:0] mag(input logic [7:0] p);
		return {4'h0, p, 4'h0};
	endfunction : mag

	always @(posedge core_clk)
	begin
		phase_voltage <= {mag(vp[2]), mag(vp[1]), mag(vp[0])};
		phase_current <= {mag(ip[2]), mag(ip[1]), mag(ip[0])};
		seq_mag       <= {mag(sp[3]), mag(sp[2]), mag(sp[1]), mag(sp[0])};
	end
endmodule : dlsup_fe_model

// >>> tb/dlsup_chk.sv
/*
 dlsup_chk: port-level checks of the line detector and vt supervisor.
 Assumes it is bound into dlsup_top and sees only its ports.
*/
`timescale 1ns/1ns
module dlsup_chk #(
	parameter int TICK_CYCLES = 10
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// inhibit and flags
	input wire logic detector_inhibit,
	input wire logic phase1_voltage_over,
	input wire logic phase2_voltage_over,
	input wire logic phase3_voltage_over,
	input wire logic phase1_current_over,
	input wire logic phase2_current_over,
	input wire logic phase3_current_over,
	input wire logic line_dead_flag,
	input wire logic line_live_flag,
	input wire logic vt_circuit_fault
);
	localparam int ARM_C  = 200 * TICK_CYCLES - 2;
	localparam int LAT_LO = 100 * TICK_CYCLES - 5;
	localparam int LAT_HI = 102 * TICK_CYCLES + 5;
	int   live_cnt;
	int   fault_cnt;
	logic armed_ok, any_over;
	assign any_over = phase1_voltage_over || phase2_voltage_over || phase3_voltage_over
		|| phase1_current_over || phase2_current_over || phase3_current_over;

	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			live_cnt <= 0;
		else if (!line_live_flag)
			live_cnt <= 0;
		else if (live_cnt < ARM_C)
			live_cnt <= live_cnt + 1;

	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			fault_cnt <= 0;
		else if (!vt_circuit_fault)
			fault_cnt <= 0;
		else if (fault_cnt < 100000)
			fault_cnt <= fault_cnt + 1;

	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			armed_ok <= 1'b0;
		else if (line_dead_flag)
			armed_ok <= 1'b0;
		else if (live_cnt >= ARM_C)
			armed_ok <= 1'b1;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	AST_LIVE_MATCHES_VOLTS: assert property (line_live_flag == $past(phase1_voltage_over
		&& phase2_voltage_over && phase3_voltage_over && !detector_inhibit))
		else $error("live flag wrong");
	AST_DEAD_NEEDS_ALL_LOW: assert property (line_dead_flag |-> !$past(any_over))
		else $error("dead flag with a flag over");
	AST_INHIBIT_CLEARS_FLAGS: assert property ($past(detector_inhibit) |-> !any_over)
		else $error("flag over while inhibited");
	AST_INHIBIT_CLEARS_STATE: assert property ($past(detector_inhibit) &&
		$past(detector_inhibit, 2) |-> !(line_dead_flag || line_live_flag || vt_circuit_fault))
		else $error("line or fault output while inhibited");
	AST_FAULT_NEEDS_ARM: assert property ($rose(vt_circuit_fault) |-> armed_ok)
		else $error("fault raised without arming");
	AST_SHORT_FAULT_DROPS: assert property ($rose(line_dead_flag) && vt_circuit_fault
		&& fault_cnt < LAT_LO |-> ##[1:4] !vt_circuit_fault) else $error("short fault kept");
	AST_LONG_FAULT_HOLDS: assert property ($rose(line_dead_flag) && vt_circuit_fault
		&& fault_cnt > LAT_HI |=> vt_circuit_fault[*8]) else $error("long fault dropped");
	AST_CLEAR_AFTER_HOLD: assert property ($fell(vt_circuit_fault) && $past(line_live_flag)
		&& !$past(detector_inhibit) |-> fault_cnt >= ARM_C) else $error("fault cleared early");
	AST_READY_ONE_CYCLE: assert property (pready |-> $past(psel) && $past(penable)
		##1 !pready) else $error("pready out of place");
	AST_SLVERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
endmodule : dlsup_chk

bind dlsup_top dlsup_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// >>> tb/dlsup_top_tb_top.sv
/*
 dlsup_top_tb_top: self-checking bench of the detector and supervisor.
 Assumes a short tick of TK cycles.
*/
`timescale 1ns/1ns
module dlsup_top_tb_top;
	localparam int TK = 10;
	logic                        core_clk, rst_b, psel, penable, pwrite, pready, pslverr, re;
	logic                        detector_inhibit, dead, live, flt;
	logic [11:0]                 paddr;
	logic [31:0]                 pwdata, prdata, rq;
	logic [2:0][7:0]             vp, ip;
	logic [3:0][7:0]             sp;
	logic [2:0]                  vo, io;
	logic [2:0]                  b, c;
	dlsup_pkg::dlsup_phase_mag_t pv, pc;
	dlsup_pkg::dlsup_seq_mag_t   sm;
	int                          err_count, total_checks;

	dlsup_fe_model fe (.core_clk(core_clk), .vp(vp), .ip(ip), .sp(sp),
		.phase_voltage(pv), .phase_current(pc), .seq_mag(sm));
	dlsup_top #(.TICK_CYCLES(TK)) dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .phase_voltage(pv), .phase_current(pc),
		.seq_mag(sm), .detector_inhibit(detector_inhibit), .phase1_voltage_over(vo[0]),
		.phase2_voltage_over(vo[1]), .phase3_voltage_over(vo[2]), .phase1_current_over(io[0]),
		.phase2_current_over(io[1]), .phase3_current_over(io[2]), .line_dead_flag(dead),
		.line_live_flag(live), .vt_circuit_fault(flt));

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x)
		begin
			err_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, x, s);
		end
	endtask : chk

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		chk("apb answer", n < 50, 1);
		rq = prdata;
		re = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	// {dead, live, i flags, v flags}, levels clear of the band
	function automatic logic [7:0] exp_flags(input logic [2:0][7:0] v, input logic [2:0][7:0] i);
		logic [5:0] o;
		for (int k = 0; k < 3; k++)
		begin
			o[k]     = v[k] > 8'h3C;
			o[3 + k] = i[k] > 8'h0A;
		end
		return {~|o, &o[2:0], o};
	endfunction : exp_flags

	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	initial
	begin
		cyc(60000);
		err_count++;
		stop_test();
	end

	initial
	begin
		{rst_b, psel, penable, pwrite, paddr, pwdata, detector_inhibit} = '0;
		{vp, ip, sp, err_count, total_checks} = '0;
		cyc(6);
		rst_b <= 1'b1;
		void'($urandom(32'h0E1C5AB4));
		apb(0, dlsup_pkg::REG_CTRL, 0);
		chk("ctrl reset", rq, 0);
		apb(0, dlsup_pkg::REG_DLD_THR, 0);
		chk("thr reset", rq, 32'h0000_0A3C);
		apb(0, dlsup_pkg::REG_SUP_THR, 0);
		chk("sup thr reset", rq, 32'h0000_0A1E);
		apb(0, 12'h010, 0);
		chk("unmapped", {re, rq[30:0]}, 32'h8000_0000);
		apb(1, dlsup_pkg::REG_DLD_THR, 32'h0000_0105);
		apb(0, dlsup_pkg::REG_DLD_THR, 0);
		chk("thr low clamp", rq, 32'h0000_020A);
		apb(1, dlsup_pkg::REG_DLD_THR, 32'h0000_6578);
		apb(0, dlsup_pkg::REG_DLD_THR, 0);
		chk("thr high clamp", rq, 32'h0000_6464);
		apb(1, dlsup_pkg::REG_DLD_THR, 32'h0000_0A3C);
		vp <= {3{8'h64}};
		cyc(4);
		chk("off flags", {dead, live, io, vo}, 0);
		apb(1, dlsup_pkg::REG_CTRL, 1);
		$display("done: settings");
		for (int n = 0; n < 40; n++)
		begin
			b = (n == 0) ? 3'h7 : (n == 1) ? 3'h0 : 3'($urandom);
			c = (n < 2) ? b : 3'($urandom);
			for (int k = 0; k < 3; k++)
			begin
				vp[k] <= b[k] ? 8'($urandom_range(100, 70)) : 8'($urandom_range(50, 0));
				ip[k] <= c[k] ? 8'($urandom_range(100, 20)) : 8'($urandom_range(8, 0));
			end
			cyc(4);
			chk("line flags", {dead, live, io, vo}, exp_flags(vp, ip));
			apb(0, dlsup_pkg::REG_STATUS, 0);
			chk("status", rq[7:0], {io, vo, live, dead});
		end
		$display("done: random line states");
		vp <= {8'h64, 8'h64, 8'h3D};
		cyc(4);
		chk("pickup", vo[0], 1);
		vp[0] <= 8'h3A;
		cyc(4);
		chk("inside release band", vo[0], 1);
		vp[0] <= 8'h38;
		cyc(4);
		chk("released", vo[0], 0);
		vp <= {3{8'h64}};
		detector_inhibit <= 1'b1;
		cyc(4);
		chk("inhibited", {dead, live, io, vo}, 0);
		detector_inhibit <= 1'b0;
		$display("done: release and inhibit");
		for (int m = 0; m < 3; m++)
		begin
			apb(1, dlsup_pkg::REG_CTRL, 32'(m * 2 + 1));
			ip <= {3{8'h32}};
			sp <= '0;
			cyc(2100);
			apb(0, dlsup_pkg::REG_STATUS, 0);
			chk("armed", rq[8], 1);
			if (m == 2)
			begin
				sp <= 32'h3200_0032;
				cyc(100);
				chk("neg current vetoes", flt, 0);
			end
			sp <= (m == 1) ? 32'h0000_3200 : 32'h3200_0000;
			cyc(35);
			chk("fault early", flt, 0);
			cyc(35);
			chk("fault", flt, 1);
			sp <= '0;
			cyc(1950);
			chk("fault held", flt, 1);
			cyc(150);
			chk("fault cleared", flt, 0);
			$display("done: mode %0d", m);
		end
		sp <= 32'h3200_0000;
		cyc(1200);
		{vp, ip, sp} <= '0;
		cyc(400);
		chk("latched", flt, 1);
		vp <= {3{8'h64}};
		ip <= {3{8'h32}};
		cyc(1950);
		chk("latched at reclose", flt, 1);
		cyc(250);
		chk("latch cleared", flt, 0);
		cyc(100);
		sp <= 32'h3200_0000;
		cyc(80);
		chk("short fault", flt, 1);
		{vp, ip, sp} <= '0;
		cyc(10);
		chk("short fault dropped", flt, 0);
		apb(0, dlsup_pkg::REG_STATUS, 0);
		chk("disarmed", rq[8], 0);
		$display("done: latch");
		stop_test();
	end
endmodule : dlsup_top_tb_top
